// >>> hw/frt_consts.svh
`ifndef FRT_CONSTS_SVH
`define FRT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register map (byte registers, 5-bit address)
// ----------------------------------------------------------------------
`define FRT_A_CNT_HI   5'h00
`define FRT_A_CNT_LO   5'h01
`define FRT_A_CAP_HI0  5'h02
`define FRT_A_SHR_HI   5'h08
`define FRT_A_SHR_LO   5'h09
`define FRT_A_CMP_HI0  5'h0a
`define FRT_A_FLAG     5'h12
`define FRT_A_MASK     5'h13
`define FRT_A_EDGE     5'h14
`define FRT_A_PULSE_ACC_CONTROL_REG    5'h15
`define FRT_A_PORT     5'h16
`define FRT_A_C1MASK   5'h17
`define FRT_A_C1DATA   5'h18
`define FRT_A_OVF      5'h19
`define FRT_A_OVF_EN   5'h1a
`define FRT_A_ACT      5'h1b

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FRT_B_PRESC_LO 0
`define FRT_B_SEL      2
`define FRT_B_DIR3     3
`define FRT_B_DIR7     7
`define FRT_B_OVF      7

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define FRT_RST_CMP    16'hffff
`define FRT_RST_BYTE   8'h00
`define FRT_CNT_MAX    16'hffff
`define FRT_DIV_1      4'h0
`define FRT_DIV_4      4'h3
`define FRT_DIV_8      4'h7
`define FRT_DIV_16     4'hf

`endif

// >>> hw/frt_pkg.sv
package frt_pkg;

  // Register bus request from the master
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } frt_bus_t;

  // Port A pad drive
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } frt_pad_t;

  // Pin synchroniser state
  typedef struct packed {
    logic [7:0] s1;
    logic [7:0] s2;
    logic [7:0] s3;
    logic [7:0] lvl;
    logic [3:0] evt;
  } frt_sync_t;

  // Timer state
  typedef struct packed {
    logic [3:0]       presc;
    logic             upd;
    logic [15:0]      cnt;
    logic             ovf;
    logic             ovf_en;
    logic [4:0][15:0] cmp;
    logic [7:0]       flag;
    logic [7:0]       mask;
    logic [7:0]       edge_ctl;
    logic [7:0]       pulse_acc_control_reg;
    logic [7:0]       port;
    logic [7:0]       c1m;
    logic [7:0]       c1d;
    logic [3:0]       act;
    logic [7:3]       pin;
    logic [4:0]       m1;
    logic [4:0]       m2;
    logic [3:0]       pend;
    logic [7:0]       rdata;
  } frt_state_t;

endpackage

// >>> hw/frt_pin_sync.sv
`timescale 1ns/10ps
`include "frt_consts.svh"

module frt_pin_sync (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Pins and edge selection
  input  wire logic [7:0] pa_in,
  input  wire logic [7:0] edge_ctl,
  // Stable levels and capture events
  output logic      [7:0] lvl,
  output logic      [3:0] evt
);
  import frt_pkg::*;

  frt_sync_t st_q;
  frt_sync_t st_d;

  // ----------------------------------------------------------------------
  // Three-stage sync, edge select per capture pin
  // ----------------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    st_d.s1  = pa_in;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    st_d.evt = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.lvl[i] = st_q.s3[i];
      end
    end
    for (int i = 0; i < 4; i++) begin
      if (st_d.lvl[i] != st_q.lvl[i]) begin
        st_d.evt[i] = (st_d.lvl[i] & edge_ctl[2*i]) |
                      (~st_d.lvl[i] & edge_ctl[2*i+1]);
      end
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lvl = st_q.lvl;
  assign evt = st_q.evt;

  AST_EDGE_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (edge_ctl[1:0] == 2'b00) |=> !evt[0])
    else $error("capture event with edge field disabled");

endmodule // frt_pin_sync

// >>> hw/frt_timer.sv
// Overview of operation
// - Prescaler divides clock by 1, 4, 8 or 16 per two select bits.
// - 16-bit counter starts at zero, wraps at all ones, sets overflow flag.
// - Software cannot reset, load or stop the counter.
// - Three captures, four compares, one shared channel, each with 16-bit register.
// - Each timer function has its own enable and its own request line.
// - Selected pin edge copies counter value into capture register.
// - Pin edges synchronised; capture taken while counter value stable.
// - Compare pin changes after a sync-like delay from the match.
// - Levels of pins 3..0 always readable in port data register.
// - Pins owned by a compare ignore port data writes.
// - Compare one drives any mix of pins 7..3 via mask and data.
// - Top pin serves as general I/O or compare one output.
// - Shared pin direction bit clears at reset, pin starts as input.
// - Select bit set gives fourth capture; clear (reset) gives fifth compare.
// - Shared pin driven as output with capture on: toggles cause captures.
// - Writes to shared register ignored while it acts as capture.
// - Two-bit edge field: off, rising, falling, any; cleared by reset.
// - High-byte capture read delays a capture one cycle, never loses it.
// - The three capture registers keep contents through reset, read as two bytes.
`timescale 1ns/10ps
`include "frt_consts.svh"

module frt_timer (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_b,
  // Register bus
  input  wire frt_pkg::frt_bus_t    bus_req,
  output logic               [7:0]  bus_rdata,
  // Port A pads
  input  wire logic          [7:0]  pa_in,
  output frt_pkg::frt_pad_t         pa_pad,
  // Interrupt requests: [7:0] channel flags, [8] overflow
  output logic               [8:0]  irq_req
);
  import frt_pkg::*;

  frt_state_t        st_q;
  frt_state_t        st_d;
  logic [2:0][15:0]  cap_q;
  logic [2:0]        cap_ld;
  logic [7:0]        pin_lvl;
  logic [3:0]        pin_evt;
  logic [3:0]        cap_req;
  logic [3:0]        cap_blk;
  logic [7:0]        flag_set;
  logic [7:0]        flag_clr;
  logic [4:0]        match;
  logic              tick;
  logic              sel_cap;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Last prescaler count for a select value
  function automatic logic [3:0] frt_div_last(input logic [1:0] sel);
    unique case (sel)
      2'b00: frt_div_last = `FRT_DIV_1;
      2'b01: frt_div_last = `FRT_DIV_4;
      2'b10: frt_div_last = `FRT_DIV_8;
      2'b11: frt_div_last = `FRT_DIV_16;
    endcase
  endfunction

  // High or low byte of a 16-bit value
  function automatic logic [7:0] frt_byte(input logic [15:0] v, input logic lo);
    frt_byte = lo ? v[7:0] : v[15:8];
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------------
  frt_pin_sync u_sync (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pa_in    (pa_in),
    .edge_ctl (st_q.edge_ctl),
    .lvl      (pin_lvl),
    .evt      (pin_evt)
  );

  assign sel_cap = st_q.pulse_acc_control_reg[`FRT_B_SEL];
  assign tick    = (st_q.presc == frt_div_last(st_q.pulse_acc_control_reg[1:0]));

  // Capture requests, held over one cycle by a high-byte read
  always_comb begin
    cap_req = {pin_evt[3] & sel_cap, pin_evt[2:0]} | st_q.pend;
    for (int i = 0; i < 4; i++) begin
      cap_blk[i] = bus_req.rd &&
                   (bus_req.addr == 5'(`FRT_A_CAP_HI0 + 2 * i));
    end
    cap_ld = cap_req[2:0] & ~cap_blk[2:0];
  end

  // Compare matches on each fresh counter value
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      match[i] = st_q.upd && (st_q.cnt == st_q.cmp[i]);
    end
    match[4] = match[4] && !sel_cap;
  end

  // Flag set and write-one-to-clear
  always_comb begin
    flag_set    = {match[3:0], 1'b0, cap_ld};
    flag_set[3] = sel_cap ? (cap_req[3] & ~cap_blk[3]) : match[4];
    flag_clr    = (bus_req.wr && bus_req.addr == `FRT_A_FLAG) ? bus_req.wdata
                                                             : 8'h00;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    st_d.upd  = 1'b0;
    st_d.presc = tick ? 4'h0 : 4'(st_q.presc + 4'h1);
    // Counter runs free and has no write path
    if (tick) begin
      st_d.cnt = 16'(st_q.cnt + 16'h1);
      st_d.upd = 1'b1;
    end
    if (tick && st_q.cnt == `FRT_CNT_MAX) begin
      st_d.ovf = 1'b1;
    end else if (bus_req.wr && bus_req.addr == `FRT_A_OVF &&
                 bus_req.wdata[`FRT_B_OVF]) begin
      st_d.ovf = 1'b0;
    end
    st_d.flag = (st_q.flag & ~flag_clr) | flag_set;
    st_d.pend = cap_req & cap_blk;
    if (cap_req[3] && !cap_blk[3] && sel_cap) begin
      st_d.cmp[4] = st_q.cnt;
    end
    // Compare pin action three cycles after the match
    st_d.m1 = match;
    st_d.m2 = st_q.m1;
    for (int i = 0; i < 4; i++) begin
      if (st_q.m2[i + 1] && st_q.act[i]) begin
        st_d.pin[6 - i] = ~st_q.pin[6 - i];
      end
    end
    if (st_q.m2[0]) begin
      for (int b = 3; b < 8; b++) begin
        if (st_q.c1m[b]) begin
          st_d.pin[b] = st_q.c1d[b];
        end
      end
    end
    // Register writes
    if (bus_req.wr) begin
      for (int i = 0; i < 4; i++) begin
        if (bus_req.addr == 5'(`FRT_A_CMP_HI0 + 2 * i)) begin
          st_d.cmp[i][15:8] = bus_req.wdata;
        end
        if (bus_req.addr == 5'(`FRT_A_CMP_HI0 + 2 * i + 1)) begin
          st_d.cmp[i][7:0] = bus_req.wdata;
        end
      end
      unique case (bus_req.addr)
        `FRT_A_SHR_HI: begin
          if (!sel_cap) begin
            st_d.cmp[4][15:8] = bus_req.wdata;
          end
        end
        `FRT_A_SHR_LO: begin
          if (!sel_cap) begin
            st_d.cmp[4][7:0] = bus_req.wdata;
          end
        end
        `FRT_A_MASK:   st_d.mask     = bus_req.wdata;
        `FRT_A_EDGE:   st_d.edge_ctl = bus_req.wdata;
        `FRT_A_PULSE_ACC_CONTROL_REG:  st_d.pulse_acc_control_reg    = bus_req.wdata;
        `FRT_A_PORT:   st_d.port     = bus_req.wdata;
        `FRT_A_C1MASK: st_d.c1m      = bus_req.wdata;
        `FRT_A_C1DATA: st_d.c1d      = bus_req.wdata;
        `FRT_A_OVF_EN: st_d.ovf_en   = bus_req.wdata[`FRT_B_OVF];
        `FRT_A_ACT:    st_d.act      = bus_req.wdata[3:0];
        default: ;
      endcase
    end
    // Read data, one cycle after the strobe
    st_d.rdata = 8'h00;
    if (bus_req.rd) begin
      for (int i = 0; i < 3; i++) begin
        if (bus_req.addr[4:1] == 4'(i + 1)) begin
          st_d.rdata = frt_byte(cap_q[i], bus_req.addr[0]);
        end
      end
      // Shared register sits just below the four compare registers
      for (int i = 0; i < 4; i++) begin
        if (bus_req.addr[4:1] == 4'(i + 5)) begin
          st_d.rdata = frt_byte(st_q.cmp[i], bus_req.addr[0]);
        end
      end
      if (bus_req.addr[4:1] == 4'h4) begin
        st_d.rdata = frt_byte(st_q.cmp[4], bus_req.addr[0]);
      end
      unique case (bus_req.addr)
        `FRT_A_CNT_HI: st_d.rdata = st_q.cnt[15:8];
        `FRT_A_CNT_LO: st_d.rdata = st_q.cnt[7:0];
        `FRT_A_FLAG:   st_d.rdata = st_q.flag;
        `FRT_A_MASK:   st_d.rdata = st_q.mask;
        `FRT_A_EDGE:   st_d.rdata = st_q.edge_ctl;
        `FRT_A_PULSE_ACC_CONTROL_REG:  st_d.rdata = st_q.pulse_acc_control_reg;
        `FRT_A_PORT:   st_d.rdata = pin_lvl;
        `FRT_A_C1MASK: st_d.rdata = st_q.c1m;
        `FRT_A_C1DATA: st_d.rdata = st_q.c1d;
        `FRT_A_OVF:    st_d.rdata = {st_q.ovf, 7'h00};
        `FRT_A_OVF_EN: st_d.rdata = {st_q.ovf_en, 7'h00};
        `FRT_A_ACT:    st_d.rdata = {4'h0, st_q.act};
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q     <= '0;
      st_q.cmp <= {5{`FRT_RST_CMP}};
    end else begin
      st_q <= st_d;
    end
  end

  // Capture latches, untouched by reset
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < 3; i++) begin
      if (cap_ld[i]) begin
        cap_q[i] <= st_q.cnt;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pads and requests
  // ----------------------------------------------------------------------
  always_comb begin
    pa_pad.out = st_q.port;
    pa_pad.oe  = {st_q.pulse_acc_control_reg[`FRT_B_DIR7], 3'b111, st_q.pulse_acc_control_reg[`FRT_B_DIR3], 3'b000};
    for (int i = 0; i < 4; i++) begin
      if ((st_q.act[i] && !(i == 3 && sel_cap)) || st_q.c1m[6 - i]) begin
        pa_pad.out[6 - i] = st_q.pin[6 - i];
      end
    end
    if (st_q.c1m[7]) begin
      pa_pad.out[7] = st_q.pin[7];
    end
  end

  assign bus_rdata = st_q.rdata;
  assign irq_req   = {st_q.ovf & st_q.ovf_en, st_q.flag & st_q.mask};

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_WRAP: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tick && st_q.cnt == `FRT_CNT_MAX) |=> (st_q.cnt == 16'h0000) && st_q.ovf)
    else $error("counter wrap did not clear count and set overflow");

  AST_DIV4: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tick && st_q.pulse_acc_control_reg[1:0] == 2'b01) ##1 (st_q.pulse_acc_control_reg[1:0] == 2'b01)[*3]
    |=> tick)
    else $error("divide by four tick spacing wrong");

  AST_NO_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !tick |=> $stable(st_q.cnt))
    else $error("counter changed without a prescaler tick");

  AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cap_ld[0] |=> cap_q[0] == $past(st_q.cnt))
    else $error("capture did not latch the counter");

  AST_HOLD_CAP: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (cap_req[0] && cap_blk[0]) |=> cap_ld[0])
    else $error("blocked capture was not retried next cycle");

  AST_SHR_RO: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (sel_cap && !cap_req[3]) |=> $stable(st_q.cmp[4]))
    else $error("shared register changed while acting as capture");

  AST_OVF_STICKY: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st_q.ovf && !(bus_req.wr && bus_req.addr == `FRT_A_OVF)) |=> st_q.ovf)
    else $error("overflow flag dropped without a clear");

  AST_CMP_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (match[1] && st_q.act[0]) ##2
    (st_q.act[0] && !(st_q.m2[0] && st_q.c1m[6])) |=> (st_q.pin[6] != $past(st_q.pin[6])))
    else $error("compare pin did not toggle three cycles after match");

  AST_PORT_RD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (bus_req.rd && bus_req.addr == `FRT_A_PORT) |=> bus_rdata == $past(pin_lvl))
    else $error("port read does not show pin levels");

  AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!rst_b)
    cap_ld[1] |=> st_q.flag[1])
    else $error("capture flag not set");

  AST_DIV1: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tick && st_q.pulse_acc_control_reg[1:0] == 2'b00) |=> (tick || st_q.pulse_acc_control_reg[1:0] != 2'b00))
    else $error("divide by one missed a tick");

  AST_DIV8: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (tick && st_q.pulse_acc_control_reg[1:0] == 2'b10) ##1 (st_q.pulse_acc_control_reg[1:0] == 2'b10)[*7]
    |=> tick)
    else $error("divide by eight tick spacing wrong");

  AST_CNT_STEP: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tick |=> (st_q.cnt == 16'($past(st_q.cnt) + 16'h1)))
    else $error("counter did not step by one on a tick");

  AST_OWNED_PIN: assert property (@(posedge clk_sys) disable iff (!rst_b)
    st_q.act[0] |-> (pa_pad.out[6] == st_q.pin[6]))
    else $error("owned pin follows port data");

  AST_PIN7_DATA: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !st_q.c1m[7] |-> (pa_pad.out[7] == st_q.port[7]))
    else $error("top pin not showing port data");

  AST_SHR_CAP: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (sel_cap && cap_req[3] && !cap_blk[3]) |=> (st_q.cmp[4] == $past(st_q.cnt)))
    else $error("fourth capture did not latch the counter");

  AST_FIFTH_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $past(sel_cap) |-> !st_q.m1[4])
    else $error("fifth compare matched while channel captures");

  AST_CMP_FLAG: assert property (@(posedge clk_sys) disable iff (!rst_b)
    match[1] |=> st_q.flag[5])
    else $error("compare flag not set on match");

  AST_FLAG_CLR: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (flag_clr[0] && !flag_set[0]) |=> !st_q.flag[0])
    else $error("capture flag not cleared by write of one");

  AST_C1_DATA: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st_q.m2[0] && st_q.c1m[5]) |=> (st_q.pin[5] == $past(st_q.c1d[5])))
    else $error("compare one data not placed on masked pin");

endmodule // frt_timer

// >>> dv/frt_pin_model.sv
`timescale 1ns/10ps

module frt_pin_model (
  // Pad drive from the timer
  input  wire frt_pkg::frt_pad_t pad,
  // Levels from outside sources on undriven pins
  input  wire logic [7:0]        ext,
  // Resolved pin levels back to the timer
  output logic      [7:0]        pa_in
);
  import frt_pkg::*;

  // A driven pin follows the timer, an undriven one the outside source
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pa_in[i] = pad.oe[i] ? pad.out[i] : ext[i];
    end
  end

endmodule // frt_pin_model

// >>> dv/free_running_timer_input_capture_tb_top.sv
`timescale 1ns/10ps
`include "frt_consts.svh"

module free_running_timer_input_capture_tb_top;
  import frt_pkg::*;

  // Expected read: kind 0 absolute, 1 step from reference, 2 store reference
  typedef struct packed {
    logic [1:0] k;
    logic [7:0] e;
    logic [7:0] t;
  } frt_exp_t;

  logic        clk_sys;
  logic        rst_b;
  frt_bus_t    bus_req;
  logic [7:0]  bus_rdata;
  logic [7:0]  pa_in;
  logic [7:0]  ext;
  frt_pad_t    pa_pad;
  logic [8:0]  irq_req;
  frt_exp_t    exp_q[$];
  frt_exp_t    x;
  logic [7:0]  dv;
  logic [7:0]  ref_v;
  logic [7:0]  pv;
  logic [7:0]  d1;
  logic [7:0]  r1;
  logic [15:0] tv;
  logic        rd_d1;
  int          bad_count;
  int          n_checks;
  int          cyc;
  int          t0;
  int          e;

  frt_timer frt_timer_i (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .bus_req   (bus_req),
    .bus_rdata (bus_rdata),
    .pa_in     (pa_in),
    .pa_pad    (pa_pad),
    .irq_req   (irq_req)
  );

  frt_pin_model frt_pin_model_i (
    .pad   (pa_pad),
    .ext   (ext),
    .pa_in (pa_in)
  );

  // Clock and cycle count
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic chk_ok(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Read data is compared in the cycle after the strobe, oldest note first
  always @(posedge clk_sys) begin
    rd_d1 <= bus_req.rd;
    if (rd_d1 === 1'b1) begin
      x = exp_q.pop_front();
      if (x.k == 2'd2) begin
        ref_v = bus_rdata;
      end else begin
        dv = bus_rdata - (x.k == 2'd1 ? ref_v : 8'h00) - x.e;
        if (x.k == 2'd1) ref_v = bus_rdata;
        chk_ok(((^bus_rdata) !== 1'bx) && (dv <= x.t), "read data");
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [1:0] k, input logic [7:0] ev,
                    input logic [7:0] t);
    @(posedge clk_sys);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    exp_q.push_back('{k: k, e: ev, t: t});
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
  endtask

  task automatic wait_hi(input int b, input int lim);
    int n;
    n = 0;
    while (irq_req[b] !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= lim) begin
      bad_count++;
      $display("[ERR] %0t wait limit", $time);
      conclude();
    end
  endtask

  task automatic test_end(input string s);
    $display("test %s done", s);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    bus_req = '0;
    ext = 8'h00;
    rst_b = 1'b0;
    cyc = 0;
    bad_count = 0;
    n_checks = 0;
    rd_d1 = 1'b0;
    void'($urandom(32'hb38e174a));
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    t0 = cyc + 1;
    chk_ok(pa_pad.oe === 8'h70 && irq_req === 9'h000, "reset pads");
    rd(`FRT_A_PULSE_ACC_CONTROL_REG, 2'd0, 8'h00, 8'd0);
    rd(`FRT_A_EDGE, 2'd0, 8'h00, 8'd0);
    rd(`FRT_A_SHR_HI, 2'd0, 8'hff, 8'd0);
    rd(`FRT_A_CNT_HI, 2'd0, 8'h00, 8'd0);
    rd(`FRT_A_CNT_LO, 2'd0, 8'(cyc - t0), 8'd4);
    test_end("reset");

    // Every edge mode against a rising and a falling pin edge
    for (int m = 0; m < 4; m++) begin
      wr(`FRT_A_EDGE, 8'(m));
      wr(`FRT_A_FLAG, 8'h01);
      ext[0] <= 1'b1;
      e = cyc - t0;
      // Last mode reads the high byte in the cycle the capture is due
      repeat ((m == 3) ? 3 : 8) @(posedge clk_sys);
      if (m == 3) begin
        rd(`FRT_A_CAP_HI0, 2'd0, 8'h00, 8'd0);
        rd(5'h03, 2'd0, 8'(e), 8'd8);
      end
      rd(`FRT_A_FLAG, 2'd0, {7'h00, m[0]}, 8'd0);
      wr(`FRT_A_FLAG, 8'h01);
      ext[0] <= 1'b0;
      repeat (8) @(posedge clk_sys);
      rd(`FRT_A_FLAG, 2'd0, {7'h00, m[1]}, 8'd0);
    end
    chk_ok(irq_req[0] === 1'b0, "masked request");
    wr(`FRT_A_MASK, 8'h01);
    @(posedge clk_sys);
    chk_ok(irq_req[0] === 1'b1, "enabled request");
    wr(`FRT_A_FLAG, 8'h01);
    @(posedge clk_sys);
    chk_ok(irq_req === 9'h000, "cleared request");
    wr(`FRT_A_MASK, 8'h00);
    test_end("capture");

    // Compare one drives the upper pins, port writes are kept off them
    tv = 16'(cyc - t0 + 60);
    d1 = 8'($urandom) & 8'hf8;
    pv = ~d1;
    wr(`FRT_A_PULSE_ACC_CONTROL_REG, 8'h88);
    wr(`FRT_A_C1MASK, 8'hf8);
    wr(`FRT_A_C1DATA, d1);
    wr(`FRT_A_PORT, pv);
    wr(`FRT_A_CMP_HI0, tv[15:8]);
    wr(5'h0b, tv[7:0]);
    repeat (70) @(posedge clk_sys);
    chk_ok(pa_pad.out[7:3] === d1[7:3] && pa_pad.oe === 8'hf8, "compare pins");
    rd(`FRT_A_FLAG, 2'd0, 8'h10, 8'd0);
    wr(`FRT_A_PORT, pv);
    @(posedge clk_sys);
    chk_ok(pa_pad.out[7:3] === d1[7:3], "owned pins");
    test_end("compare");

    // Shared channel as compare store, then as capture
    wr(`FRT_A_C1MASK, 8'h00);
    r1 = 8'($urandom);
    wr(`FRT_A_SHR_HI, r1);
    rd(`FRT_A_SHR_HI, 2'd0, r1, 8'd0);
    wr(`FRT_A_PULSE_ACC_CONTROL_REG, 8'h8c);
    wr(`FRT_A_SHR_HI, ~r1);
    rd(`FRT_A_SHR_HI, 2'd0, r1, 8'd0);
    wr(`FRT_A_EDGE, 8'h3f);
    ext[2:0] <= 3'($urandom) | 3'b010;
    repeat (8) @(posedge clk_sys);
    rd(`FRT_A_PORT, 2'd0, {pv[7:3], ext[2:0]}, 8'd0);
    wr(`FRT_A_EDGE, 8'hc0);
    wr(`FRT_A_FLAG, 8'hff);
    pv[3] = ~pv[3];
    wr(`FRT_A_PORT, pv);
    repeat (8) @(posedge clk_sys);
    rd(`FRT_A_FLAG, 2'd0, 8'h08, 8'd0);
    test_end("shared");

    // Count step over 64 clocks for each prescale, counter writes ignored
    for (int p = 0; p < 4; p++) begin
      wr(`FRT_A_PULSE_ACC_CONTROL_REG, 8'(p));
      repeat (20) @(posedge clk_sys);
      rd(`FRT_A_CNT_LO, 2'd2, 8'h00, 8'd0);
      wr(`FRT_A_CNT_HI, 8'h00);
      wr(`FRT_A_CNT_LO, 8'h00);
      repeat (58) @(posedge clk_sys);
      rd(`FRT_A_CNT_LO, 2'd1, 8'(64 / (p == 0 ? 1 : (2 << p))), 8'd0);
    end
    test_end("prescale");

    // Roll-over sets a sticky flag that requests only when enabled
    wr(`FRT_A_PULSE_ACC_CONTROL_REG, 8'h00);
    chk_ok(irq_req[8] === 1'b0, "overflow idle");
    wr(`FRT_A_OVF_EN, 8'h80);
    wr(`FRT_A_ACT, 8'h01);
    wr(`FRT_A_PORT, d1);
    wait_hi(8, 70000);
    repeat (50) @(posedge clk_sys);
    chk_ok(pa_pad.out[6] === ~d1[6], "compare toggle");
    rd(`FRT_A_OVF, 2'd0, 8'h80, 8'd0);
    wr(`FRT_A_OVF, 8'h80);
    rd(`FRT_A_OVF, 2'd0, 8'h00, 8'd0);
    chk_ok(irq_req[8] === 1'b0, "overflow cleared");
    repeat (3) @(posedge clk_sys);
    test_end("overflow");
    conclude();
  end

endmodule // free_running_timer_input_capture_tb_top
